//--- include/mie_pkg.sv
// package: map, fields, levels and carriers of the irq enable and drop counter bank
package mie_pkg;

  // register byte offsets on the host register port
  localparam logic [7:0] IRQ_EN_OFFSET = 8'h38;
  localparam logic [7:0] DROP_CNT_OFFSET = 8'h40;

  // enable bit positions; each cause bit of the status register sits at the same place
  localparam int NORMAL_SUM_BIT = 16;
  localparam int ABNORMAL_SUM_BIT = 15;
  localparam int EARLY_RX_BIT = 14;
  localparam int TIMER_OVF_BIT = 11;
  localparam int EARLY_TX_BIT = 10;
  localparam int RX_STOPPED_BIT = 8;
  localparam int RX_NOBUF_BIT = 7;
  localparam int RX_DONE_BIT = 6;
  localparam int TX_UNDERFLOW_BIT = 5;
  localparam int TX_NOBUF_BIT = 2;
  localparam int TX_STOPPED_BIT = 1;
  localparam int TX_DONE_BIT = 0;

  // implemented bits, reset values and the fill of unimplemented bits
  localparam logic [31:0] IRQ_EN_WR_MASK = 32'h0001_CDE7;
  localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;
  localparam logic [31:0] RESERVED_FILL = 32'h0000_0000;
  localparam logic [31:0] NORMAL_CAUSES = 32'h0000_4845;
  localparam logic [31:0] ABNORMAL_CAUSES = 32'h0000_05A2;

  // dropped frame counter fields
  localparam int FIFO_OVF_FLAG_BIT = 28;
  localparam int FIFO_CNT_LSB = 17;
  localparam int FIFO_CNT_W = 11;
  localparam int MISSED_OVF_BIT = 16;
  localparam int MISSED_CNT_LSB = 0;
  localparam int MISSED_CNT_W = 16;
  localparam int HIGH_BYTE_LANE = 3;

  // operation mode fields feeding the threshold decode and receive control
  localparam int TX_SF_BIT = 21;
  localparam int TX_THR_SHORT_BIT = 22;
  localparam int TX_THR_LSB = 14;
  localparam int RX_START_BIT = 1;

  // transmit threshold levels in bytes, index 3 first
  localparam int THR_W = 11;
  localparam logic [3:0][10:0] TX_THR_SHORT = {11'h100, 11'h080, 11'h080, 11'h040};
  localparam logic [3:0][10:0] TX_THR_LONG = {11'h400, 11'h200, 11'h100, 11'h080};
  localparam logic [10:0] THR_RESET = 11'h080;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } mie_csr_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } mie_csr_rsp_s;

  typedef enum logic [1:0] {
    RX_STOPPED = 2'h0,
    RX_RUNNING = 2'h1,
    RX_SUSPENDED = 2'h3
  } mie_rx_state_e;

endpackage

//--- rtl/mie_drop_counter.sv
// one dropped-frame counter with its sticky overflow flag
`timescale 1ns/10ps
`default_nettype none

module mie_drop_counter #(
  parameter int unsigned WIDTH = 11
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // events and host clear
  input wire logic count_event,
  input wire logic clear,
  // state
  output logic [WIDTH-1:0] count,
  output logic overflow
);

  // an event in the clearing cycle is counted into the fresh value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= count_event ? WIDTH'(1) : '0;
    end else if (count_event) begin
      count <= count + WIDTH'(1);
    end
  end

  // wrap sets the flag outside the clearing cycle; a wrap in the clearing cycle clears it and restarts the count at one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (count_event && (&count) && !clear) begin
      overflow <= 1'b1;
    end else if (clear) begin
      overflow <= 1'b0;
    end
  end

endmodule // mie_drop_counter

`default_nettype wire

//--- rtl/mie_irq_bank.sv
// interrupt enable register, dropped frame counters, threshold decode and rx suspend
//
// Summary of operation
// - threshold mode clear: field picks 64..256 or 128..1024 bytes; set: store-and-forward
// - normal summary enable opens transmit done, tx no-buffer, rx done, timer, early rx
// - abnormal summary enable opens tx stopped, underflow, rx no-buffer, rx stopped, early tx
// - early receive cause needs its enable and the normal summary enable
// - timer overflow cause needs its enable and the normal summary enable
// - early transmit cause needs its enable and the abnormal summary enable
// - receive stopped cause needs its enable and the abnormal summary enable
// - receive no-buffer cause needs its enable and the abnormal summary enable
// - receive done cause needs its enable and the normal summary enable
// - transmit underflow cause needs its enable and the abnormal summary enable
// - transmit no-buffer cause needs its enable and the normal summary enable
// - transmit stopped cause needs its enable and the abnormal summary enable
// - transmit done cause needs its enable and the normal summary enable
// - unimplemented bits read a fixed value and ignore writes
// - fifo drop counter overflow sets bit 28, cleared by high byte read
// - bits 27:17 count fifo overflow drops, cleared by high byte read
// - missed counter overflow sets bit 16, cleared by high byte read
// - bits 15:0 count frames missed for lack of descriptor, cleared by high byte read
// - host-owned descriptor suspends receive and raises the rx no-buffer status
`timescale 1ns/10ps
`default_nettype none

module mie_irq_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host register port
  input wire mie_pkg::mie_csr_req_s csr_req,
  output mie_pkg::mie_csr_rsp_s csr_rsp,
  // operation mode and status register contents
  input wire logic [31:0] operation_mode_register,
  input wire logic [31:0] status_register,
  // transmit threshold
  output logic [10:0] tx_threshold_bytes,
  output logic tx_store_forward,
  // interrupt
  output logic irq,
  output logic normal_irq_pending,
  output logic abnormal_irq_pending,
  // receive drop events
  input wire logic fifo_overflow_drop,
  input wire logic rx_frame_arrive,
  input wire logic frame_cache_full,
  input wire logic rx_desc_avail,
  // receive descriptor handling
  input wire logic rx_desc_check,
  input wire logic rx_desc_host_owned,
  input wire logic rx_busy,
  output logic rx_suspended,
  output logic rx_stopped,
  output logic rx_nobuf_set
);

  // interrupt enable register
  logic [31:0] interrupt_enable;
  logic [31:0] next_interrupt_enable;

  // host access decode
  logic rd_strobe;
  logic wr_strobe;
  logic hit_irq_en;
  logic hit_drop_cnt;
  logic high_byte_read;

  // counter widths, taken from the register field layout
  localparam int FIFO_W = mie_pkg::FIFO_CNT_W;
  localparam int MISS_W = mie_pkg::MISSED_CNT_W;

  // counter state
  logic [FIFO_W-1:0] fifo_drop_count;
  logic fifo_count_overflow;
  logic [MISS_W-1:0] missed_frame_count;
  logic missed_count_overflow;
  logic missed_frame_event;
  logic [31:0] dropped_frame_counters;

  // interrupt gating
  logic normal_summary_enable;
  logic abnormal_summary_enable;
  logic [31:0] cause_gate;
  logic [31:0] live_causes;

  // threshold decode
  logic [1:0] thr_sel;
  logic [10:0] next_threshold;
  logic next_store_forward;

  // receive process
  mie_pkg::mie_rx_state_e rx_state;
  mie_pkg::mie_rx_state_e next_rx_state;
  logic rx_start;
  logic next_rx_nobuf_set;

  // host access decode
  assign rd_strobe = csr_req.valid && !csr_req.write;
  assign wr_strobe = csr_req.valid && csr_req.write;
  assign hit_irq_en = (csr_req.addr == mie_pkg::IRQ_EN_OFFSET);
  assign hit_drop_cnt = (csr_req.addr == mie_pkg::DROP_CNT_OFFSET);

  // only the top lane clears, so narrow hosts can read low bytes without losing counts
  assign high_byte_read = rd_strobe && hit_drop_cnt
    && csr_req.be[mie_pkg::HIGH_BYTE_LANE];

  // interrupt enable writes, byte lane by byte lane
  always_comb begin
    next_interrupt_enable = interrupt_enable;
    for (int lane = 0; lane < 4; lane++) begin
      if (wr_strobe && hit_irq_en && csr_req.be[lane]) begin
        next_interrupt_enable[lane*8 +: 8] = csr_req.wdata[lane*8 +: 8];
      end
    end
    // unimplemented positions keep their fixed value
    next_interrupt_enable = (next_interrupt_enable & mie_pkg::IRQ_EN_WR_MASK)
      | (mie_pkg::RESERVED_FILL & ~mie_pkg::IRQ_EN_WR_MASK);
  end

  // reset leaves every cause masked
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      interrupt_enable <= mie_pkg::IRQ_EN_RESET;
    end else begin
      interrupt_enable <= next_interrupt_enable;
    end
  end

  // summary enables
  assign normal_summary_enable = interrupt_enable[mie_pkg::NORMAL_SUM_BIT];
  assign abnormal_summary_enable = interrupt_enable[mie_pkg::ABNORMAL_SUM_BIT];

  // per-cause gates: individual enable and its summary enable
  always_comb begin
    cause_gate = 32'h0000_0000;
    cause_gate[mie_pkg::EARLY_RX_BIT] =
      interrupt_enable[mie_pkg::EARLY_RX_BIT] && normal_summary_enable;
    cause_gate[mie_pkg::TIMER_OVF_BIT] =
      interrupt_enable[mie_pkg::TIMER_OVF_BIT] && normal_summary_enable;
    cause_gate[mie_pkg::EARLY_TX_BIT] =
      interrupt_enable[mie_pkg::EARLY_TX_BIT] && abnormal_summary_enable;
    cause_gate[mie_pkg::RX_STOPPED_BIT] =
      interrupt_enable[mie_pkg::RX_STOPPED_BIT] && abnormal_summary_enable;
    cause_gate[mie_pkg::RX_NOBUF_BIT] =
      interrupt_enable[mie_pkg::RX_NOBUF_BIT] && abnormal_summary_enable;
    cause_gate[mie_pkg::RX_DONE_BIT] =
      interrupt_enable[mie_pkg::RX_DONE_BIT] && normal_summary_enable;
    cause_gate[mie_pkg::TX_UNDERFLOW_BIT] =
      interrupt_enable[mie_pkg::TX_UNDERFLOW_BIT] && abnormal_summary_enable;
    cause_gate[mie_pkg::TX_NOBUF_BIT] =
      interrupt_enable[mie_pkg::TX_NOBUF_BIT] && normal_summary_enable;
    cause_gate[mie_pkg::TX_STOPPED_BIT] =
      interrupt_enable[mie_pkg::TX_STOPPED_BIT] && abnormal_summary_enable;
    cause_gate[mie_pkg::TX_DONE_BIT] =
      interrupt_enable[mie_pkg::TX_DONE_BIT] && normal_summary_enable;
  end

  // status bits outside the two cause groups never reach the line
  assign live_causes = status_register & cause_gate
    & (mie_pkg::NORMAL_CAUSES | mie_pkg::ABNORMAL_CAUSES);

  // registered so the pin never glitches on a status update
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |live_causes;
    end
  end

  // per-group pending flags, so software can tell which group to service
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      normal_irq_pending <= 1'b0;
    end else begin
      normal_irq_pending <= |(live_causes & mie_pkg::NORMAL_CAUSES);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      abnormal_irq_pending <= 1'b0;
    end else begin
      abnormal_irq_pending <= |(live_causes & mie_pkg::ABNORMAL_CAUSES);
    end
  end

  // transmit threshold decode
  assign thr_sel = operation_mode_register[mie_pkg::TX_THR_LSB +: 2];

  always_comb begin
    next_store_forward = operation_mode_register[mie_pkg::TX_SF_BIT];
    if (operation_mode_register[mie_pkg::TX_THR_SHORT_BIT]) begin
      next_threshold = mie_pkg::TX_THR_SHORT[thr_sel];
    end else begin
      next_threshold = mie_pkg::TX_THR_LONG[thr_sel];
    end
  end

  // level is held even in store-and-forward; the flag alone decides
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_threshold_bytes <= mie_pkg::THR_RESET;
    end else begin
      tx_threshold_bytes <= next_threshold;
    end
  end

  // store-and-forward flag
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_store_forward <= 1'b0;
    end else begin
      tx_store_forward <= next_store_forward;
    end
  end

  // a frame is missed only when the cache cannot hold it and no descriptor waits
  assign missed_frame_event = rx_frame_arrive && frame_cache_full && !rx_desc_avail;

  mie_drop_counter #(
    .WIDTH(FIFO_W)
  ) u_fifo_drop (
    .mclk(mclk),
    .rst_n(rst_n),
    .count_event(fifo_overflow_drop),
    .clear(high_byte_read),
    .count(fifo_drop_count),
    .overflow(fifo_count_overflow)
  );

  mie_drop_counter #(
    .WIDTH(MISS_W)
  ) u_missed (
    .mclk(mclk),
    .rst_n(rst_n),
    .count_event(missed_frame_event),
    .clear(high_byte_read),
    .count(missed_frame_count),
    .overflow(missed_count_overflow)
  );

  // counter register image; read returns the value before the clear
  always_comb begin
    dropped_frame_counters = mie_pkg::RESERVED_FILL;
    dropped_frame_counters[mie_pkg::FIFO_OVF_FLAG_BIT] = fifo_count_overflow;
    dropped_frame_counters[mie_pkg::FIFO_CNT_LSB +: FIFO_W] = fifo_drop_count;
    dropped_frame_counters[mie_pkg::MISSED_OVF_BIT] = missed_count_overflow;
    dropped_frame_counters[mie_pkg::MISSED_CNT_LSB +: MISS_W] = missed_frame_count;
  end

  // one-cycle answer; writes to the counters are acknowledged and ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      csr_rsp <= '0;
    end else begin
      csr_rsp.ack <= csr_req.valid;
      if (rd_strobe && hit_irq_en) begin
        csr_rsp.rdata <= interrupt_enable;
      end else if (rd_strobe && hit_drop_cnt) begin
        csr_rsp.rdata <= dropped_frame_counters;
      end else begin
        // unmapped offsets and writes answer zero
        csr_rsp.rdata <= 32'h0000_0000;
      end
    end
  end

  // receive process: stopped, running, suspended on a host-owned descriptor
  assign rx_start = operation_mode_register[mie_pkg::RX_START_BIT];

  always_comb begin
    next_rx_state = rx_state;
    next_rx_nobuf_set = 1'b0;
    unique case (rx_state)
      mie_pkg::RX_STOPPED: begin
        if (rx_start) begin
          next_rx_state = mie_pkg::RX_RUNNING;
        end
      end
      mie_pkg::RX_RUNNING: begin
        // stop waits for the frame in flight to finish
        if (!rx_start && !rx_busy) begin
          next_rx_state = mie_pkg::RX_STOPPED;
        end else if (rx_desc_check && rx_desc_host_owned) begin
          next_rx_state = mie_pkg::RX_SUSPENDED;
          next_rx_nobuf_set = 1'b1;
        end
      end
      mie_pkg::RX_SUSPENDED: begin
        if (!rx_start && !rx_busy) begin
          next_rx_state = mie_pkg::RX_STOPPED;
        end else if (rx_desc_check && !rx_desc_host_owned) begin
          next_rx_state = mie_pkg::RX_RUNNING;
        end
      end
      default: begin
        next_rx_state = mie_pkg::RX_STOPPED;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_state <= mie_pkg::RX_STOPPED;
    end else begin
      rx_state <= next_rx_state;
    end
  end

  // outputs mirror the next state so they line up with the state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_suspended <= 1'b0;
    end else begin
      rx_suspended <= (next_rx_state == mie_pkg::RX_SUSPENDED);
    end
  end

  // stopped at reset, until the start bit is seen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_stopped <= 1'b1;
    end else begin
      rx_stopped <= (next_rx_state == mie_pkg::RX_STOPPED);
    end
  end

  // one-cycle request to set the no-buffer status bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_nobuf_set <= 1'b0;
    end else begin
      rx_nobuf_set <= next_rx_nobuf_set;
    end
  end

endmodule // mie_irq_bank

`default_nettype wire

//--- testbench/mie_irq_bank_sva.sv
// assertions for the irq enable and drop counter bank
`timescale 1ns/10ps
`default_nettype none
module mie_irq_bank_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire mie_pkg::mie_csr_req_s csr_req,
  input wire mie_pkg::mie_csr_rsp_s csr_rsp,
  // mode and status
  input wire logic [31:0] operation_mode_register,
  input wire logic [31:0] status_register,
  // outputs watched
  input wire logic [10:0] tx_threshold_bytes,
  input wire logic tx_store_forward,
  input wire logic irq,
  input wire logic normal_irq_pending,
  input wire logic abnormal_irq_pending,
  input wire logic rx_suspended,
  input wire logic rx_nobuf_set
);
  wire logic [1:0] sel = operation_mode_register[15:14];
  // short table repeats 128 at select 2 and tops out at 256, so no plain shift there
  wire logic [10:0] thr_exp = operation_mode_register[22] ?
    ((sel == 2'h3) ? 11'h100 : (sel == 2'h2) ? 11'h080 : 11'h040 << sel) : 11'h080 << sel;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    csr_req.valid;
  endsequence
  sequence s_rd_en;
    s_req ##0 !csr_req.write && csr_req.addr == mie_pkg::IRQ_EN_OFFSET;
  endsequence
  sequence s_rd_cnt;
    s_req ##0 !csr_req.write && csr_req.addr == mie_pkg::DROP_CNT_OFFSET;
  endsequence
  a_ack_follows: assert property (s_req |=> csr_rsp.ack) else $error("no ack");
  a_ack_caused: assert property (csr_rsp.ack |-> $past(csr_req.valid))
    else $error("ack without request");
  a_resv_en_zero: assert property (s_rd_en |=> (csr_rsp.rdata & 32'hFFFE_3218) == 32'h0)
    else $error("enable reserved bits");
  a_resv_cnt_zero: assert property (s_rd_cnt |=> csr_rsp.rdata[31:29] == 3'h0)
    else $error("counter reserved bits");
  a_thr_level: assert property (!operation_mode_register[21] |=>
    tx_threshold_bytes == $past(thr_exp) && !tx_store_forward) else $error("threshold level");
  a_sf_mode: assert property (operation_mode_register[21] |=> tx_store_forward)
    else $error("store and forward");
  a_irq_groups: assert property (irq == (normal_irq_pending | abnormal_irq_pending))
    else $error("irq vs pending");
  a_irq_quiet: assert property (status_register == 32'h0 |=> !irq)
    else $error("irq without cause");
  a_norm_cause: assert property (normal_irq_pending |->
    $past(|(status_register & 32'h0000_4845))) else $error("normal pending");
  a_abn_cause: assert property (abnormal_irq_pending |->
    $past(|(status_register & 32'h0000_05A2))) else $error("abnormal pending");
  a_nobuf_pulse: assert property (rx_nobuf_set |=> !rx_nobuf_set)
    else $error("nobuf pulse long");
  a_nobuf_susp: assert property (rx_nobuf_set |-> rx_suspended)
    else $error("nobuf without suspend");
endmodule // mie_irq_bank_sva
`default_nettype wire

//--- testbench/mie_host_model.sv
// host processor model driving the register port
`timescale 1ns/10ps
`default_nettype none
module mie_host_model (
  // clock
  input wire logic mclk,
  // register port
  output var mie_pkg::mie_csr_req_s csr_req,
  input wire mie_pkg::mie_csr_rsp_s csr_rsp
);
  initial csr_req = '0;
  // one strobe cycle; a longer strobe would be taken as a second request
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge mclk);
    csr_req <= '{1'b1, w, a, b, d};
    @(negedge mclk);
    q = (csr_rsp.ack === 1'b1) ? csr_rsp.rdata : 'x;
    csr_req.valid <= 1'b0;
    csr_req.wdata <= ~d;
  endtask
endmodule // mie_host_model
`default_nettype wire

//--- testbench/tb_top.sv
// testbench for the irq enable and drop counter bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0] IEN = mie_pkg::IRQ_EN_OFFSET;
  localparam logic [7:0] DCO = mie_pkg::DROP_CNT_OFFSET;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  mie_pkg::mie_csr_req_s csr_req;
  mie_pkg::mie_csr_rsp_s csr_rsp;
  logic [31:0] op = 32'h0;
  logic [31:0] st = 32'h0;
  logic [31:0] rd;
  logic [10:0] tx_threshold_bytes;
  logic tx_store_forward, irq, normal_irq_pending, abnormal_irq_pending;
  logic rx_suspended, rx_stopped, rx_nobuf_set;
  logic fod = 1'b0, arr = 1'b0, cfull = 1'b0, davl = 1'b0;
  logic dchk = 1'b0, dhost = 1'b0, busy = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  mie_host_model H (.mclk, .csr_req, .csr_rsp);
  mie_irq_bank DUT (.mclk, .rst_n, .csr_req, .csr_rsp,
    .operation_mode_register(op), .status_register(st),
    .tx_threshold_bytes, .tx_store_forward, .irq, .normal_irq_pending,
    .abnormal_irq_pending, .fifo_overflow_drop(fod), .rx_frame_arrive(arr),
    .frame_cache_full(cfull), .rx_desc_avail(davl), .rx_desc_check(dchk),
    .rx_desc_host_owned(dhost), .rx_busy(busy), .rx_suspended, .rx_stopped,
    .rx_nobuf_set);
  task automatic end_of_test;
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    H.acc(1'b1, a, 4'hF, d, rd);
  endtask
  // long runs of held events cover both counter wraps
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic t_reset;
    chk(tx_threshold_bytes === 11'h080 && rx_stopped === 1'b1, "reset outputs");
    H.acc(1'b0, IEN, 4'hF, 32'h0, rd);
    chk(rd === 32'h0, "enable reset");
  endtask
  task automatic t_thr;
    logic [10:0] ts [4] = '{11'h040, 11'h080, 11'h080, 11'h100};
    logic [10:0] tl [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
    for (int i = 0; i < 8; i++) begin
      op = {9'h0, i[2], 6'h0, i[1:0], 14'h0};
      cy(2);
      chk(tx_threshold_bytes === (i[2] ? ts[i[1:0]] : tl[i[1:0]]), "level");
      op[21] = 1'b1;
      cy(2);
      chk(tx_store_forward === 1'b1, "store forward");
    end
    op = 32'h0;
  endtask
  task automatic t_irq;
    int cb[10] = '{0, 2, 6, 11, 14, 1, 5, 7, 8, 10};
    logic [31:0] s, o, c;
    for (int i = 0; i < 10; i++) begin
      s = (i < 5) ? 32'h0001_0000 : 32'h0000_8000;
      o = (i < 5) ? 32'h0000_8000 : 32'h0001_0000;
      c = 32'h1 << cb[i];
      st = c;
      wr(IEN, c | o);
      cy(2);
      chk(irq === 1'b0, "wrong summary");
      wr(IEN, s);
      cy(2);
      chk(irq === 1'b0, "summary only");
      wr(IEN, c | s);
      cy(2);
      chk(irq === 1'b1 && normal_irq_pending === (i < 5), "enabled cause");
      chk(abnormal_irq_pending === (i >= 5), "abnormal group");
      st = 32'h0;
      cy(2);
      chk(irq === 1'b0, "cause gone");
    end
  endtask
  task automatic t_resv;
    wr(IEN, 32'hFFFF_FFFF);
    H.acc(1'b0, IEN, 4'hF, 32'h0, rd);
    chk(rd === 32'h0001_CDE7, "enable bits");
    wr(IEN, 32'h0);
    wr(DCO, 32'hFFFF_FFFF);
    H.acc(1'b0, DCO, 4'hF, 32'h0, rd);
    chk(rd === 32'h0, "counter write");
    H.acc(1'b0, 8'h3C, 4'hF, 32'h0, rd);
    chk(rd === 32'h0, "unmapped read");
  endtask
  task automatic t_cnt;
    fod = 1'b1;
    cy(3);
    fod = 1'b0;
    cfull = 1'b1;
    arr = 1'b1;
    cy(2);
    davl = 1'b1;
    cy(1);
    {arr, cfull, davl} = 3'h0;
    H.acc(1'b0, DCO, 4'h7, 32'h0, rd);
    chk(rd === 32'h0006_0002, "low read");
    H.acc(1'b0, DCO, 4'hF, 32'h0, rd);
    chk(rd === 32'h0006_0002, "high read");
    H.acc(1'b0, DCO, 4'hF, 32'h0, rd);
    chk(rd === 32'h0, "cleared");
    {fod, arr, cfull} = 3'h7;
    cy(65537);
    {fod, arr, cfull} = 3'h0;
    H.acc(1'b0, DCO, 4'hF, 32'h0, rd);
    chk(rd === 32'h1003_0001, "wraps");
    H.acc(1'b0, DCO, 4'hF, 32'h0, rd);
    chk(rd === 32'h0, "flags cleared");
  endtask
  task automatic t_rx;
    int n = 0;
    op = 32'h2;
    cy(2);
    chk(rx_stopped === 1'b0 && rx_suspended === 1'b0, "running");
    {dchk, dhost} = 2'h3;
    cy(1);
    {dchk, dhost} = 2'h0;
    repeat (3) begin
      if (rx_nobuf_set === 1'b1) n++;
      cy(1);
    end
    chk(n == 1 && rx_suspended === 1'b1, "suspend");
    dchk = 1'b1;
    cy(1);
    dchk = 1'b0;
    cy(2);
    chk(rx_suspended === 1'b0, "resume");
    busy = 1'b1;
    op = 32'h0;
    cy(3);
    chk(rx_stopped === 1'b0, "busy holds");
    busy = 1'b0;
    cy(2);
    chk(rx_stopped === 1'b1, "stopped");
  endtask
  initial begin
    cy(20);
    rst_n = 1'b1;
    cy(2);
    t_reset();
    t_thr();
    t_irq();
    t_resv();
    t_cnt();
    t_rx();
    end_of_test();
  end
endmodule // tb_top
bind mie_irq_bank mie_irq_bank_sva u_sva (.mclk, .rst_n, .csr_req, .csr_rsp,
  .operation_mode_register, .status_register, .tx_threshold_bytes, .tx_store_forward,
  .irq, .normal_irq_pending, .abnormal_irq_pending, .rx_suspended, .rx_nobuf_set);
`default_nettype wire
